// file: hdl/wpc_defs.svh
// Purpose: Constants for the write precompensation and head toggle block
// Assumes: 40 MHz ref_clk, APB slave with 32-bit data
// Notes:   Counts are derived from the times; tick and window are
//          programmable inside their tolerance ranges
//
// What this block does
// - Each raw write pulse the buffer accepts opens a compensation window of about 1 us.
// - Early and late are caught on the pulse and steer that pulse's tap.
// - A repeating tick of 150-250 ns, nominally 170 ns, runs in the window.
// - Ticks shift a register whose early, on-time, late taps rise in turn.
// - Late flag picks late tap, early flag early tap, neither on-time.
// - The chosen tap reaches the drive stream only with precomp enabled.
// - At window end the taps clear and the engine idles for the next pulse.
// - The head flip-flop toggles on each leading edge of the stream.
// - With write gate, head set drives the positive winding, cleared the negative one.
// - Without write gate the head flip-flop is held clear.
`ifndef WPC_DEFS_SVH
`define WPC_DEFS_SVH

`define WPC_CLK_NS        25
`define WPC_WIN_MIN_NS    900
`define WPC_WIN_MAX_NS    1000
`define WPC_TICK_MIN_NS   150
`define WPC_TICK_NOM_NS   170
`define WPC_TICK_MAX_NS   250

`define WPC_WIN_MIN_CYC   ((`WPC_WIN_MIN_NS + `WPC_CLK_NS - 1) / `WPC_CLK_NS)
`define WPC_WIN_MAX_CYC   (`WPC_WIN_MAX_NS / `WPC_CLK_NS)
`define WPC_TICK_MIN_CYC  ((`WPC_TICK_MIN_NS + `WPC_CLK_NS - 1) / `WPC_CLK_NS)
`define WPC_TICK_MAX_CYC  (`WPC_TICK_MAX_NS / `WPC_CLK_NS)
`define WPC_TICK_NOM_CYC  ((`WPC_TICK_NOM_NS + `WPC_CLK_NS / 2) / `WPC_CLK_NS)

`define WPC_CTRL_OFF      12'h000
`define WPC_STATUS_OFF    12'h004
`define WPC_OVR_OFF       12'h008

`define WPC_CTRL_PCE      0
`define WPC_CTRL_TICK_LSB 8
`define WPC_CTRL_TICK_MSB 11
`define WPC_CTRL_WIN_LSB  16
`define WPC_CTRL_WIN_MSB  21

`define WPC_ST_HEAD       0
`define WPC_ST_BUSY       1
`define WPC_ST_GATE       2
`define WPC_ST_FULL       3
`define WPC_ST_CNT_LSB    16

`define WPC_PCE_RST       1'b0

`endif

// file: hdl/wpc_pkg.sv
// Purpose: Types for the write precompensation block
// Assumes: Constants live in wpc_defs.svh
// Notes:   None
package wpc_pkg;

  typedef struct packed {
    logic early;
    logic late;
  } wpc_flags_t;

  typedef enum logic [0:0] {
    WPC_IDLE = 1'b0,
    WPC_RUN  = 1'b1
  } wpc_state_t;

endpackage : wpc_pkg

// file: hdl/wpc_fifo.sv
// Purpose: Small valid/ready buffer between pulse capture and the engine
// Assumes: DEPTH is a power of two
// Notes:   Push while full is refused through inReady
module wpc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wrPtr;
  logic [AW-1:0]    next_rdPtr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_comb begin
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage has no reset; entries are only read once valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

endmodule : wpc_fifo

// file: hdl/wpc_top.sv
// Purpose: Write precompensation and head-drive toggle with APB control
// Assumes: Raw pulse, flags and write gate are asynchronous pins
// Notes:   One-shots are replaced by ref_clk counters; a pulse arriving
//          while the engine runs waits in a two-entry buffer, or is lost when both entries are full
//
// Design decisions made here: the APB slave port and the placing of the registers.
`include "wpc_defs.svh"

module wpc_top (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                raw_write_pulse,
  input  wire logic                early_in,
  input  wire logic                late_in,
  input  wire logic                write_gate_in,
  output logic                     pulseReady,
  output logic                     compensated_write_stream,
  output logic                     head_drive_pos,
  output logic                     head_drive_neg,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr
);
  import wpc_pkg::*;

  localparam logic [3:0] TICK_MIN = 4'(`WPC_TICK_MIN_CYC);
  localparam logic [3:0] TICK_MAX = 4'(`WPC_TICK_MAX_CYC);
  localparam logic [3:0] TICK_NOM = 4'(`WPC_TICK_NOM_CYC);
  localparam logic [5:0] WIN_MIN  = 6'(`WPC_WIN_MIN_CYC);
  localparam logic [5:0] WIN_MAX  = 6'(`WPC_WIN_MAX_CYC);

  // Reset release
  logic [1:0] rstPipe;
  logic       rstSync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe[1];

  // Pin synchronisers: stage one feeds stage two only
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  logic       pulseLast;
  logic       pulseRise;
  logic       gateSync;
  wpc_flags_t flagSync;

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinMeta   <= 4'h0;
      pinSync   <= 4'h0;
      pulseLast <= 1'b0;
    end else begin
      pinMeta   <= {write_gate_in, late_in, early_in, raw_write_pulse};
      pinSync   <= pinMeta;
      pulseLast <= pinSync[0];
    end
  end

  assign pulseRise      = pinSync[0] & ~pulseLast;
  assign flagSync = '{early: pinSync[1], late: pinSync[2]};
  assign gateSync       = pinSync[3];

  // Control register fields
  logic       precompEnable;
  logic [3:0] tickCycles;
  logic [5:0] winCycles;
  logic       next_precompEnable;
  logic [3:0] next_tickCycles;
  logic [5:0] next_winCycles;

  // Capture buffer; flags travel with their pulse
  wpc_flags_t capFlags;
  wpc_flags_t bufFlags;
  logic       bufValid;
  logic       bufPop;

  assign capFlags = flagSync;

  wpc_fifo #(
    .WIDTH ($bits(wpc_flags_t)),
    .DEPTH (2)
  ) u_buf (
    .clk      (ref_clk),
    .rst_n    (rstSync_n),
    .inValid  (pulseRise),
    .inReady  (pulseReady),
    .inData   (capFlags),
    .outValid (bufValid),
    .outReady (bufPop),
    .outData  (bufFlags)
  );

  // Compensation engine
  wpc_state_t state;
  wpc_state_t next_state;
  wpc_flags_t heldFlags;
  wpc_flags_t next_heldFlags;
  logic [5:0] winCnt;
  logic [5:0] next_winCnt;
  logic [3:0] tickCnt;
  logic [3:0] next_tickCnt;
  logic [2:0] taps;
  logic [2:0] next_taps;
  logic       tick;
  logic       selTap;
  logic       streamNext;
  logic       stream;

  assign bufPop = (state == WPC_IDLE) & bufValid;
  assign tick   = (state == WPC_RUN) && (tickCnt == 4'h0);

  always_comb begin
    next_state     = state;
    next_heldFlags = heldFlags;
    next_winCnt    = winCnt;
    next_tickCnt   = tickCnt;
    next_taps      = taps;
    case (state)
      WPC_IDLE: begin
        next_taps = 3'h0;
        if (bufValid) begin
          next_heldFlags = bufFlags;
          next_winCnt    = winCycles - 6'h1;
          next_tickCnt   = tickCycles - 4'h1;
          next_state     = WPC_RUN;
        end
      end
      WPC_RUN: begin
        if (tick) begin
          next_tickCnt = tickCycles - 4'h1;
          next_taps    = {taps[1:0], 1'b1};
        end else begin
          next_tickCnt = tickCnt - 4'h1;
        end
        if (winCnt == 6'h0) begin
          next_taps  = 3'h0;
          next_state = WPC_IDLE;
        end else begin
          next_winCnt = winCnt - 6'h1;
        end
      end
      default: begin
        next_state = WPC_IDLE;
        next_taps  = 3'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state     <= WPC_IDLE;
      heldFlags <= '0;
      winCnt    <= 6'h0;
      tickCnt   <= 4'h0;
      taps      <= 3'h0;
    end else begin
      state     <= next_state;
      heldFlags <= next_heldFlags;
      winCnt    <= next_winCnt;
      tickCnt   <= next_tickCnt;
      taps      <= next_taps;
    end
  end

  // Late wins if a faulty controller raises both flags
  always_comb begin
    if (heldFlags.late) begin
      selTap = taps[2];
    end else if (heldFlags.early) begin
      selTap = taps[0];
    end else begin
      selTap = taps[1];
    end
    streamNext = selTap & precompEnable;
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stream <= 1'b0;
    end else begin
      stream <= streamNext;
    end
  end

  assign compensated_write_stream = stream;

  // Head drive flip-flop
  logic headFf;
  logic next_headFf;
  logic streamLast;
  logic gateLast;

  always_comb begin
    if (!gateSync) begin
      next_headFf = 1'b0;
    end else if (stream & ~streamLast) begin
      next_headFf = ~headFf;
    end else begin
      next_headFf = headFf;
    end
  end

  // Current only flows while the gate is open
  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      headFf         <= 1'b0;
      streamLast     <= 1'b0;
      gateLast       <= 1'b0;
      head_drive_pos <= 1'b0;
      head_drive_neg <= 1'b0;
    end else begin
      headFf         <= next_headFf;
      streamLast     <= stream;
      gateLast       <= gateSync;
      head_drive_pos <= next_headFf & gateSync;
      head_drive_neg <= ~next_headFf & gateSync;
    end
  end

  // Statistics: pulses taken and pulses lost to a full buffer
  logic [15:0] pulseCount;
  logic [15:0] next_pulseCount;
  logic [15:0] overrunCount;
  logic [15:0] next_overrunCount;
  logic        overrunEvent;

  assign overrunEvent = pulseRise & ~pulseReady;

  // APB decode
  logic apbWrite;
  logic apbRead;
  logic hitCtrl;
  logic hitStatus;
  logic hitOvr;
  logic hitAny;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] wdMasked;
  logic [31:0] ctrlWord;

  assign pready    = 1'b1;
  assign apbWrite  = psel & penable & pwrite;
  assign apbRead   = psel & penable & ~pwrite;
  assign hitCtrl   = (paddr == `WPC_CTRL_OFF);
  assign hitStatus = (paddr == `WPC_STATUS_OFF);
  assign hitOvr    = (paddr == `WPC_OVR_OFF);
  assign hitAny    = hitCtrl | hitStatus | hitOvr;

  always_comb begin
    ctrlWord = 32'h0;
    ctrlWord[`WPC_CTRL_PCE] = precompEnable;
    ctrlWord[`WPC_CTRL_TICK_MSB:`WPC_CTRL_TICK_LSB] = tickCycles;
    ctrlWord[`WPC_CTRL_WIN_MSB:`WPC_CTRL_WIN_LSB] = winCycles;
  end

  generate
    for (genvar b = 0; b < 4; b++) begin : g_strb
      assign wdMasked[8*b +: 8] = pstrb[b] ? pwdata[8*b +: 8]
                                           : ctrlWord[8*b +: 8];
    end
  endgenerate

  // Out-of-range timing is clamped so the window always fits three ticks
  always_comb begin
    next_precompEnable = precompEnable;
    next_tickCycles    = tickCycles;
    next_winCycles     = winCycles;
    if (apbWrite && hitCtrl) begin
      next_precompEnable = wdMasked[`WPC_CTRL_PCE];
      next_tickCycles = wdMasked[`WPC_CTRL_TICK_MSB:`WPC_CTRL_TICK_LSB];
      next_winCycles  = wdMasked[`WPC_CTRL_WIN_MSB:`WPC_CTRL_WIN_LSB];
      if (next_tickCycles < TICK_MIN) next_tickCycles = TICK_MIN;
      if (next_tickCycles > TICK_MAX) next_tickCycles = TICK_MAX;
      if (next_winCycles < WIN_MIN) next_winCycles = WIN_MIN;
      if (next_winCycles > WIN_MAX) next_winCycles = WIN_MAX;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      precompEnable <= `WPC_PCE_RST;
      tickCycles    <= TICK_NOM;
      winCycles     <= WIN_MAX;
    end else begin
      precompEnable <= next_precompEnable;
      tickCycles    <= next_tickCycles;
      winCycles     <= next_winCycles;
    end
  end

  // Counters: a new event in the clearing cycle still counts
  always_comb begin
    next_pulseCount   = pulseCount;
    next_overrunCount = overrunCount;
    if (gateSync & ~gateLast) begin
      next_pulseCount = 16'h0;
    end
    if (bufPop) begin
      next_pulseCount = next_pulseCount + 16'h1;
    end
    if (apbWrite && hitOvr) begin
      next_overrunCount = 16'h0;
    end
    if (overrunEvent && (next_overrunCount != 16'hffff)) begin
      next_overrunCount = next_overrunCount + 16'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pulseCount   <= 16'h0;
      overrunCount <= 16'h0;
    end else begin
      pulseCount   <= next_pulseCount;
      overrunCount <= next_overrunCount;
    end
  end

  // Read data is registered for the setup cycle, valid in access
  always_comb begin
    next_prdata  = 32'h0;
    next_pslverr = 1'b0;
    if (psel && !penable && !pwrite) begin
      if (hitCtrl) begin
        next_prdata = ctrlWord;
      end else if (hitStatus) begin
        next_prdata[`WPC_ST_HEAD] = headFf;
        next_prdata[`WPC_ST_BUSY] = (state == WPC_RUN) | bufValid;
        next_prdata[`WPC_ST_GATE] = gateSync;
        next_prdata[`WPC_ST_FULL] = ~pulseReady;
        next_prdata[`WPC_ST_CNT_LSB +: 16] = pulseCount;
      end else if (hitOvr) begin
        next_prdata[15:0] = overrunCount;
      end
    end
    if (psel && !penable && !hitAny) begin
      next_pslverr = 1'b1;
    end
  end

  logic [31:0] rdHold;
  logic        errHold;

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdHold  <= 32'h0;
      errHold <= 1'b0;
    end else begin
      rdHold  <= next_prdata;
      errHold <= next_pslverr;
    end
  end

  assign prdata  = (apbRead) ? rdHold : 32'h0;
  assign pslverr = psel & penable & errHold;

endmodule : wpc_top

// file: dv/wpc_top_props.sv
// Purpose: Port checks of the write precomp and head toggle block
// Assumes: Gate and pulse pins pass two sync stages before use
// Notes:   Window bounds use the widest legal settings
module wpc_top_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic raw_write_pulse,
  input wire logic write_gate_in,
  input wire logic pulseReady,
  input wire logic compensated_write_stream,
  input wire logic head_drive_pos,
  input wire logic head_drive_neg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] quiet;
  logic [7:0] next_quiet;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Quiet time since the last pin pulse; saturates so it never wraps
  always_comb begin
    next_quiet = quiet;
    if (raw_write_pulse)
      next_quiet = 8'h00;
    else if (quiet != 8'hff)
      next_quiet = quiet + 8'h01;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      quiet <= 8'h00;
    else
      quiet <= next_quiet;
  end
  property p_drive_excl;
    !(head_drive_pos && head_drive_neg);
  endproperty
  a_drive_excl: assert property (p_drive_excl)
    else $error("both windings driven");
  property p_neg_follows;
    write_gate_in [*8] |-> head_drive_neg != head_drive_pos;
  endproperty
  a_neg_follows: assert property (p_neg_follows)
    else $error("no winding driven with gate");
  property p_gate_off;
    !write_gate_in [*4] |=> !head_drive_pos && !head_drive_neg;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("drive without gate");
  property p_head_toggle;
    write_gate_in [*5] ##0 $rose(compensated_write_stream)
      |=> head_drive_pos != $past(head_drive_pos);
  endproperty
  a_head_toggle: assert property (p_head_toggle)
    else $error("head did not toggle");
  property p_head_hold;
    write_gate_in [*5] ##0 !$rose(compensated_write_stream)
      |=> $stable(head_drive_pos);
  endproperty
  a_head_hold: assert property (p_head_hold)
    else $error("head toggled without edge");
  property p_win_min;
    $rose(compensated_write_stream) |-> compensated_write_stream [*6];
  endproperty
  a_win_min: assert property (p_win_min)
    else $error("stream pulse too short");
  property p_win_max;
    $rose(compensated_write_stream) |-> ##[1:40] !compensated_write_stream;
  endproperty
  a_win_max: assert property (p_win_max)
    else $error("stream outlived window");
  property p_idle_quiet;
    quiet >= 8'h96 |-> !compensated_write_stream;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("stream active while idle");
  c_stream: cover property ($rose(compensated_write_stream));
  c_neg: cover property ($rose(head_drive_neg));
  c_full: cover property ($fell(pulseReady));
endmodule : wpc_top_props

bind wpc_top wpc_top_props i_wpc_top_props (.ref_clk, .rst_n,
  .raw_write_pulse, .write_gate_in, .pulseReady,
  .compensated_write_stream, .head_drive_pos, .head_drive_neg);

// file: dv/wpc_ctl_model.sv
// Purpose: Pulse source standing for the disk controller chip
// Assumes: Flags settle before the pulse and hold past the sync delay
// Notes:   Flags flip afterwards so stale values never look valid
module wpc_ctl_model (
  input wire logic ref_clk,
  output logic     raw_write_pulse,
  output logic     early_in,
  output logic     late_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    raw_write_pulse = 1'b0;
    early_in = 1'b0;
    late_in = 1'b0;
  end
  task automatic send(input logic e, input logic l);
    @(posedge ref_clk);
    early_in <= e;
    late_in <= l;
    repeat (3) @(posedge ref_clk);
    raw_write_pulse <= 1'b1;
    repeat (3) @(posedge ref_clk);
    raw_write_pulse <= 1'b0;
    repeat (2) @(posedge ref_clk);
    early_in <= ~e;
    late_in <= ~l;
  endtask : send
endmodule : wpc_ctl_model

// file: dv/tb_write_precomp_and_head_toggle.sv
// Purpose: Self-checking bench for the precomp and head toggle block
// Assumes: Zero-wait APB slave, default tick 7 and window 40 cycles
// Notes:   Tap order is judged by relative delays, immune to sync skew
module tb_write_precomp_and_head_toggle;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        write_gate_in = 1'b0;
  logic        raw_write_pulse, early_in, late_in, pulseReady;
  logic        compensated_write_stream, head_drive_pos, head_drive_neg;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, rawQ = 1'b0, strQ = 1'b0, hd = 1'b0;
  int          num_errors = 0, checked = 0, cyc = 0, tPin = 0;
  int          tRise = -1, tFall = 0;
  int          d[4], w[4];

  always #12.5 ref_clk = ~ref_clk;

  wpc_top i_wpc_top (.ref_clk, .rst_n, .raw_write_pulse, .early_in,
    .late_in, .write_gate_in, .pulseReady, .compensated_write_stream,
    .head_drive_pos, .head_drive_neg, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr);
  wpc_ctl_model i_wpc_ctl_model (.ref_clk, .raw_write_pulse, .early_in,
    .late_in);

  // Edge times in cycles, sampled before the edge's own updates land
  always @(posedge ref_clk) begin
    cyc++;
    if (raw_write_pulse && !rawQ) tPin = cyc;
    if (compensated_write_stream && !strQ) tRise = cyc;
    if (!compensated_write_stream && strQ) tFall = cyc;
    rawQ = raw_write_pulse;
    strQ = compensated_write_stream;
  end

  task automatic close_out();
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] v, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic shot(input logic e, input logic l, output int dd,
                      output int ww);
    i_wpc_ctl_model.send(e, l);
    repeat (60) @(posedge ref_clk);
    dd = tRise - tPin;
    ww = tFall - tRise;
  endtask : shot

  initial begin
    repeat (6000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'h0028_0700);
    chk({pready, er}, 32'h2);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    chk({rd[30:0], er}, 32'h1);
    write_gate_in <= 1'b1;
    shot(1'b0, 1'b0, d[0], w[0]);
    chk(tRise, 32'hffff_ffff);
    chk({head_drive_pos, head_drive_neg}, 32'h1);
    apb(1'b1, 12'h000, 32'h0030_0301, rd, er);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'h0028_0601);
    // Bytes 0 and 3 keep their old values; tick clamps from above, window from below
    pstrb <= 4'h6;
    apb(1'b1, 12'h000, 32'h001f_0f00, rd, er);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0, rd, er);
    chk(rd, 32'h0024_0a01);
    apb(1'b1, 12'h000, 32'h0028_0701, rd, er);
    // Index bit 0 asks early, bit 1 late; both set must pick late
    for (int k = 0; k < 4; k++) begin
      shot(k[0], k[1], d[k], w[k]);
      hd = ~hd;
      chk({head_drive_pos, head_drive_neg}, {hd, ~hd});
    end
    chk(d[0] - d[1], 7);
    chk(d[2] - d[0], 7);
    chk(d[3], d[2]);
    chk(w[0], 26);
    chk(w[1], 33);
    chk(w[3], 19);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk({rd[31:16], rd[2:0]}, {16'h0005, 3'b100});
    apb(1'b1, 12'h000, 32'h0024_0a01, rd, er);
    shot(1'b0, 1'b0, d[0], w[0]);
    shot(1'b1, 1'b0, d[1], w[1]);
    chk(d[0] - d[1], 10);
    chk(w[0], 16);
    chk(w[1], 26);
    write_gate_in <= 1'b0;
    shot(1'b0, 1'b0, d[0], w[0]);
    chk({head_drive_pos, head_drive_neg}, 32'h0);
    apb(1'b1, 12'h000, 32'h0028_0701, rd, er);
    write_gate_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    // One runs, two wait, the last two find the buffer full
    repeat (5) i_wpc_ctl_model.send(1'b0, 1'b1);
    chk(pulseReady, 32'h0);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk(rd, 32'h2);
    apb(1'b1, 12'h008, 32'h0, rd, er);
    apb(1'b0, 12'h008, 32'h0, rd, er);
    chk(rd, 32'h0);
    repeat (200) @(posedge ref_clk);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk({rd[31:16], rd[3:0]}, {16'h0003, 4'b0101});
    close_out();
  end
endmodule : tb_write_precomp_and_head_toggle
